// >>> fe_cmp_if.sv
/*
 Carrier between the supervisor and its magnitude comparator.
 Assumes both ends sit in the same clock domain; all signals combinational.
*/
`timescale 1ns/10ps
`default_nettype none
interface fe_cmp_if;
    import fe_pkg::*;
    logic signed [POS_W-1:0]   cmd_pos;
    logic signed [POS_W-1:0]   enc_pos;
    logic        [LIMIT_W-1:0] limit;
    logic        [MAG_W-1:0]   magnitude;
    logic                      exceeds;

    modport calc (input cmd_pos, enc_pos, limit, output magnitude, exceeds);
    modport user (output cmd_pos, enc_pos, limit, input magnitude, exceeds);
endinterface : fe_cmp_if
`default_nettype wire

// >>> fe_pkg.sv
/*
 Shared constants and types for the following-error supervisor and the
 second event trigger. Assumes a 200 MHz system clock.
*/
package fe_pkg;
    // Data widths
    localparam int POS_W   = 32;
    localparam int MAG_W   = 33;
    localparam int LIMIT_W = 16;
    localparam int SET_W   = 16;
    localparam int CODE_W  = 8;
    localparam int ATT_W   = 8;
    localparam int TIME_W  = 16;
    localparam int TICK_W  = 18;

    // Error codes
    localparam logic [CODE_W-1:0] ERR_NONE      = 8'h00;
    localparam logic [CODE_W-1:0] ERR_NEG_LIMIT = 8'h13;
    localparam logic [CODE_W-1:0] ERR_FOLLOWING = 8'h85;
    localparam logic [CODE_W-1:0] ERR_CORR_FAIL = 8'h89;

    // Limit range and start value (0.05 rev in encoder counts)
    localparam logic [LIMIT_W-1:0] LIMIT_MAX   = 16'h7FFF;
    localparam int ENC_COUNTS_PER_REV           = 4000;
    localparam int REV_FRACTION_PERMILLE        = 50;
    localparam logic [LIMIT_W-1:0] LIMIT_INIT  =
        LIMIT_W'(ENC_COUNTS_PER_REV * REV_FRACTION_PERMILLE / 1000);

    // Retry time unit: 1 ms, as clock cycles
    localparam int CLK_MHZ           = 200;
    localparam int RETRY_UNIT_NS     = 1000000;
    localparam int RETRY_UNIT_CYCLES = RETRY_UNIT_NS * CLK_MHZ / 1000;

    // Configured error action
    typedef enum logic [1:0] {
        ACT_DISABLED = 2'b00,
        ACT_STOP     = 2'b01,
        ACT_CORRECT  = 2'b10,
        ACT_RESTART  = 2'b11
    } err_action_t;

    // Supervisor state
    typedef enum logic {
        ST_MONITOR      = 1'b0,
        ST_RESTART_WAIT = 1'b1
    } fe_state_t;
endpackage : fe_pkg

// >>> following_error_and_event_trigger.sv
/*
 Second event trigger arming/polarity and following-error supervision
 with stop, correct and restart actions. Assumes all inputs synchronous to
 clk_in, and one-cycle pulses for the write, update and start strobes.
*/
// Behaviour
// R1 - Zero setting disarms registration trigger
// R2 - Arming allowed while move in progress
// R3 - Disarm ignored once registration cycle begun
// R4 - Positive setting arms, rising edge
// R5 - Negative setting arms, falling edge
// R6 - Event level readable as input two
// R7 - Following error is absolute position difference
// R8 - Check only closed loop, action enabled
// R9 - Stop action: code 133, stop motion
// R10 - Correct action: new move, limited attempts
// R11 - Restart action: restart after retry time
// R12 - Limit reloaded at reset and start
// R13 - Negative limit write raises code 19
// R14 - Oversize limit clamps to 32767 counts
// R15 - Limit readable as stored setting
// R16 - Homing trigger by polarity, never disarmed
// R17 - Registration trigger starts index portion
// R18 - Strict compare every position update
// R19 - Attempts exhausted: stop, flag failure
`timescale 1ns/10ps
`default_nettype none
module following_error_and_event_trigger
    import fe_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = RETRY_UNIT_CYCLES
)
(
    input  wire logic                      clk_in,
    input  wire logic                      rst_in,
    input  wire logic                      event_in,
    input  wire logic                      event_setting_wr_in,
    input  wire logic signed [SET_W-1:0]   event_setting_in,
    input  wire logic                      registration_active_in,
    input  wire logic                      homing_active_in,
    input  wire logic                      pos_update_in,
    input  wire logic signed [POS_W-1:0]   commanded_position_in,
    input  wire logic signed [POS_W-1:0]   measured_encoder_position_in,
    input  wire logic                      closed_loop_in,
    input  wire logic        [1:0]         error_action_in,
    input  wire logic        [ATT_W-1:0]   correction_attempts_in,
    input  wire logic        [TIME_W-1:0]  retry_time_ms_in,
    input  wire logic                      limit_wr_in,
    input  wire logic signed [POS_W-1:0]   limit_value_in,
    input  wire logic                      project_start_in,
    input  wire logic                      error_clear_in,
    output logic                           event_armed_out,
    output logic                           event_falling_out,
    output logic                           general_input2_out,
    output logic                           home_trigger_out,
    output logic                           index_start_out,
    output logic             [LIMIT_W-1:0] limit_out,
    output logic             [MAG_W-1:0]   fe_magnitude_out,
    output logic                           stop_motion_out,
    output logic                           correction_move_out,
    output logic                           restart_move_out,
    output logic                           correction_fail_out,
    output logic             [CODE_W-1:0]  error_code_out,
    output logic                           error_set_out
);
    fe_cmp_if cmp_bus ();

    logic                armed_reg,   armed_next;
    logic                falling_reg, falling_next;
    logic                event_prev_reg;
    logic                home_reg,    index_reg;
    logic [LIMIT_W-1:0]  limit_reg,   limit_next;
    logic [MAG_W-1:0]    mag_reg;
    logic [ATT_W-1:0]    attempts_reg, attempts_next;
    fe_state_t           state_reg,   state_next;
    logic [TICK_W-1:0]   tick_cnt_reg;
    logic [TIME_W-1:0]   wait_cnt_reg;
    logic                stop_reg, corr_reg, restart_reg, fail_reg;
    logic [CODE_W-1:0]   code_reg,    code_next;
    logic                err_set_reg;
    err_action_t         action;

    // Comparator hookup
    assign cmp_bus.cmd_pos = commanded_position_in;
    assign cmp_bus.enc_pos = measured_encoder_position_in;
    assign cmp_bus.limit   = limit_reg;

    following_error_magnitude u_mag (
        .bus (cmp_bus.calc)
    );

    // Event setting decode
    wire set_zero   = (event_setting_in == 16'h0000);
    wire set_neg    = event_setting_in[SET_W-1];
    wire arm_req    = event_setting_wr_in & ~set_zero; // see R2
    wire disarm_ok  = event_setting_wr_in & set_zero
                    & ~registration_active_in; // see R1, R3
    assign armed_next   = arm_req ? 1'b1 : (disarm_ok ? 1'b0 : armed_reg);
    assign falling_next = arm_req ? set_neg : falling_reg; // see R4, R5

    // Edge selection by polarity
    wire rise_edge  = event_in & ~event_prev_reg;
    wire fall_edge  = ~event_in & event_prev_reg;
    wire edge_hit   = falling_reg ? fall_edge : rise_edge;
    wire home_hit   = homing_active_in & edge_hit; // see R16
    wire index_hit  = registration_active_in & armed_reg & edge_hit; // see R17

    // Limit write decode
    wire limit_neg  = limit_wr_in & limit_value_in[POS_W-1]; // see R13
    wire limit_big  = |limit_value_in[POS_W-2:LIMIT_W-1];
    wire limit_ok   = limit_wr_in & ~limit_value_in[POS_W-1];
    wire [LIMIT_W-1:0] limit_clamped =
        limit_big ? LIMIT_MAX : limit_value_in[LIMIT_W-1:0]; // see R14
    assign limit_next = project_start_in ? LIMIT_INIT
                      : (limit_ok ? limit_clamped : limit_reg); // see R12

    // Following-error checks
    assign action      = err_action_t'(error_action_in);
    wire check_en      = pos_update_in & closed_loop_in
                       & (action != ACT_DISABLED); // see R8, R18
    wire excess        = check_en & cmp_bus.exceeds
                       & (state_reg == ST_MONITOR);
    wire attempts_left = attempts_reg < correction_attempts_in;
    wire stop_hit      = excess & (action == ACT_STOP); // see R9
    wire corr_hit      = excess & (action == ACT_CORRECT)
                       & attempts_left; // see R10
    wire fail_hit      = excess & (action == ACT_CORRECT)
                       & ~attempts_left; // see R19
    wire restart_hit   = excess & (action == ACT_RESTART);
    wire wait_done     = (state_reg == ST_RESTART_WAIT)
                       & (wait_cnt_reg == retry_time_ms_in); // see R11
    wire tick          = (tick_cnt_reg == TICK_W'(TICK_CYCLES - 1));
    wire any_err       = stop_hit | fail_hit | limit_neg;

    // Attempt counter: cleared once error is back in bounds
    assign attempts_next = project_start_in ? '0
                         : corr_hit ? attempts_reg + 8'h01
                         : (check_en & ~cmp_bus.exceeds) ? '0
                         : attempts_reg;

    // Error code priority: following error, failure, bad limit
    assign code_next = stop_hit  ? ERR_FOLLOWING
                     : fail_hit  ? ERR_CORR_FAIL
                     : limit_neg ? ERR_NEG_LIMIT
                     : error_clear_in ? ERR_NONE : code_reg;

    // Supervisor state transitions
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_MONITOR:      if (restart_hit) state_next = ST_RESTART_WAIT;
            ST_RESTART_WAIT: if (wait_done) state_next = ST_MONITOR;
        endcase
        if (project_start_in) begin
            state_next = ST_MONITOR;
        end
    end

    // Trigger registers
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            armed_reg      <= 1'b0;
            falling_reg    <= 1'b0;
            event_prev_reg <= 1'b0;
            home_reg       <= 1'b0;
            index_reg      <= 1'b0;
        end else begin
            armed_reg      <= armed_next;
            falling_reg    <= falling_next;
            event_prev_reg <= event_in; // see R6
            home_reg       <= home_hit;
            index_reg      <= index_hit;
        end
    end

    // Limit and magnitude registers
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            limit_reg <= LIMIT_INIT; // see R12
            mag_reg   <= '0;
        end else begin
            limit_reg <= limit_next;
            if (pos_update_in) mag_reg <= cmp_bus.magnitude;
        end
    end

    // Restart wait timing
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            tick_cnt_reg <= '0;
            wait_cnt_reg <= '0;
        end else if (state_reg != ST_RESTART_WAIT) begin
            tick_cnt_reg <= '0;
            wait_cnt_reg <= '0;
        end else begin
            tick_cnt_reg <= tick ? '0 : tick_cnt_reg + 18'h00001;
            if (tick) wait_cnt_reg <= wait_cnt_reg + 16'h0001;
        end
    end

    // Actions and error reporting
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_reg    <= ST_MONITOR;
            attempts_reg <= '0;
            stop_reg     <= 1'b0;
            corr_reg     <= 1'b0;
            restart_reg  <= 1'b0;
            fail_reg     <= 1'b0;
            code_reg     <= ERR_NONE;
            err_set_reg  <= 1'b0;
        end else begin
            state_reg    <= state_next;
            attempts_reg <= attempts_next;
            stop_reg     <= stop_hit | fail_hit; // see R9, R19
            corr_reg     <= corr_hit; // see R10
            restart_reg  <= wait_done; // see R11
            fail_reg     <= fail_hit | (fail_reg & ~project_start_in);
            code_reg     <= code_next;
            err_set_reg  <= any_err;
        end
    end

    // Output drive
    assign event_armed_out     = armed_reg;
    assign event_falling_out   = falling_reg;
    assign general_input2_out  = event_prev_reg;
    assign home_trigger_out    = home_reg;
    assign index_start_out     = index_reg;
    assign limit_out           = limit_reg; // see R15
    assign fe_magnitude_out    = mag_reg;
    assign stop_motion_out     = stop_reg;
    assign correction_move_out = corr_reg;
    assign restart_move_out    = restart_reg;
    assign correction_fail_out = fail_reg;
    assign error_code_out      = code_reg;
    assign error_set_out       = err_set_reg;

    // Checks
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    wire signed [MAG_W-1:0] chk_diff =
        {commanded_position_in[POS_W-1], commanded_position_in}
      - {measured_encoder_position_in[POS_W-1], measured_encoder_position_in};

    a_disarm_zero: assert property ( // see R1
        event_setting_wr_in && set_zero && !registration_active_in
        |=> !event_armed_out)
        else $error("zero setting did not disarm");
    a_arm_during_move: assert property ( // see R2
        event_setting_wr_in && !set_zero && registration_active_in
        |=> event_armed_out)
        else $error("arming refused during move");
    a_disarm_ignored: assert property ( // see R3
        event_setting_wr_in && set_zero && registration_active_in
        && event_armed_out |=> event_armed_out)
        else $error("disarm accepted during cycle");
    a_arm_rising: assert property ( // see R4
        event_setting_wr_in && !set_zero && !set_neg
        |=> event_armed_out && !event_falling_out)
        else $error("positive setting wrong");
    a_arm_falling: assert property ( // see R5
        event_setting_wr_in && set_neg
        |=> event_armed_out && event_falling_out)
        else $error("negative setting wrong");
    a_input_two: assert property ( // see R6
        ##1 general_input2_out == $past(event_in))
        else $error("input two level wrong");
    a_mag_value: assert property ( // see R7
        pos_update_in |=> fe_magnitude_out ==
        $past(chk_diff[MAG_W-1] ? MAG_W'(-chk_diff) : chk_diff))
        else $error("magnitude wrong");
    a_check_gate: assert property ( // see R8
        pos_update_in && (!closed_loop_in || action == ACT_DISABLED)
        |=> !stop_motion_out && !correction_move_out)
        else $error("check ran while gated off");
    a_stop_code: assert property ( // see R9
        check_en && cmp_bus.exceeds && state_reg == ST_MONITOR
        && action == ACT_STOP |=> stop_motion_out
        && error_code_out == ERR_FOLLOWING)
        else $error("stop action wrong");
    a_correct_move: assert property ( // see R10
        corr_hit |=> correction_move_out && !stop_motion_out)
        else $error("correction move missing");
    a_restart_delay: assert property ( // see R11
        restart_hit && retry_time_ms_in == 16'h0000
        |=> ##1 restart_move_out)
        else $error("restart timing wrong");
    a_limit_init: assert property ( // see R12
        project_start_in |=> limit_out == LIMIT_INIT)
        else $error("limit not reloaded");
    a_neg_limit: assert property ( // see R13
        limit_wr_in && limit_value_in[POS_W-1] && !stop_hit && !fail_hit
        |=> error_code_out == ERR_NEG_LIMIT && error_set_out)
        else $error("negative limit not flagged");
    a_limit_clamp: assert property ( // see R14
        limit_ok && limit_big && !project_start_in |=> limit_out == LIMIT_MAX)
        else $error("limit not clamped");
    a_home_trigger: assert property ( // see R16
        homing_active_in && edge_hit |=> home_trigger_out)
        else $error("home trigger missing");
    a_index_start: assert property ( // see R17
        index_start_out |-> $past(armed_reg && registration_active_in))
        else $error("index start without armed trigger");
    a_strict_compare: assert property ( // see R18
        check_en && cmp_bus.magnitude == {{(MAG_W-LIMIT_W){1'b0}}, limit_reg}
        |=> !stop_motion_out && !correction_move_out)
        else $error("equal error acted on");
    a_attempts_out: assert property ( // see R19
        fail_hit |=> stop_motion_out && correction_fail_out
        && error_code_out == ERR_CORR_FAIL)
        else $error("correction failure not flagged");

    c_index_taken:  cover property (index_start_out);
    c_corr_then_ok: cover property (correction_move_out ##[1:50] !excess);
    c_fail:         cover property (correction_fail_out);
    c_restart:      cover property (restart_move_out);
endmodule : following_error_and_event_trigger
`default_nettype wire

// >>> following_error_and_event_trigger_tb_top.sv
/*
 Self-checking bench for the following-error and event trigger block.
 Assumes a 200 MHz clock and a shortened retry tick of 4 cycles.
*/
`timescale 1ns/10ps
`default_nettype none
module following_error_and_event_trigger_tb_top;
    import fe_pkg::*;
    localparam int TICK = 4;
    logic clk_in, rst_in, sensor, ev_wr, reg_act, homing, pos_upd;
    logic closed, lim_wr, proj, err_clr;
    logic signed [SET_W-1:0] ev_set;
    logic signed [POS_W-1:0] cmd_pos, enc_pos, lim_val, lag;
    logic [1:0]        act;
    logic [ATT_W-1:0]  atts;
    logic [TIME_W-1:0] retry;
    logic ev, armed, fall, gin2, home, idx, stop, corr, rstm, cfail, eset;
    logic [LIMIT_W-1:0] lim_o;
    logic [MAG_W-1:0]   mag_o;
    logic [CODE_W-1:0]  code_o;
    int bad_count, n_tests, seed, lim_m, att_m, n;
    bit armed_m, fall_m, prev_m, fail_m, wait_m;
    logic [7:0] code_m;
    int         wr_seq [6] = '{1, -1, 0, 7, -300, 0};

    motor_side_model far_u (.clk_in(clk_in), .rst_in(rst_in), .lag_in(lag),
        .sensor_in(sensor), .stop_in(stop), .go_in(corr | rstm),
        .cmd_pos_out(cmd_pos), .enc_pos_out(enc_pos), .event_out(ev));

    following_error_and_event_trigger #(.TICK_CYCLES(TICK)) dut_u (
        .clk_in(clk_in), .rst_in(rst_in), .event_in(ev),
        .event_setting_wr_in(ev_wr), .event_setting_in(ev_set),
        .registration_active_in(reg_act), .homing_active_in(homing),
        .pos_update_in(pos_upd), .commanded_position_in(cmd_pos),
        .measured_encoder_position_in(enc_pos), .closed_loop_in(closed),
        .error_action_in(act), .correction_attempts_in(atts),
        .retry_time_ms_in(retry), .limit_wr_in(lim_wr),
        .limit_value_in(lim_val), .project_start_in(proj),
        .error_clear_in(err_clr), .event_armed_out(armed),
        .event_falling_out(fall), .general_input2_out(gin2),
        .home_trigger_out(home), .index_start_out(idx),
        .limit_out(lim_o), .fe_magnitude_out(mag_o),
        .stop_motion_out(stop), .correction_move_out(corr),
        .restart_move_out(rstm), .correction_fail_out(cfail),
        .error_code_out(code_o), .error_set_out(eset));

    // Clock, 5 ns period
    initial begin
        clk_in = 1'b0;
        forever #2.5 clk_in = ~clk_in;
    end

    task automatic tick;
        @(posedge clk_in);
        #1;
    endtask : tick

    task automatic chk_bit(input string nm, input logic e, input logic g);
        n_tests++;
        if (g !== e) begin
            bad_count++;
            $display("mismatch %s expected %b seen %b", nm, e, g);
        end
    endtask : chk_bit

    task automatic chk_val(input string nm, input logic [32:0] e,
                           input logic [32:0] g);
        n_tests++;
        if (g !== e) begin
            bad_count++;
            $display("mismatch %s expected %0h seen %0h", nm, e, g);
        end
    endtask : chk_val

    // Setting write; zero is refused while registration runs
    task automatic ev_write(input int v);
        ev_set = SET_W'(v);
        ev_wr = 1'b1;
        tick();
        ev_wr = 1'b0;
        if (v != 0) begin
            armed_m = 1'b1;
            fall_m = (v < 0);
        end else if (!reg_act)
            armed_m = 1'b0;
        chk_bit("armed", armed_m, armed);
        chk_bit("falling", fall_m, fall);
        tick();
    endtask : ev_write

    // Sensor level step; edge of chosen polarity fires triggers
    task automatic trig(input bit lvl);
        bit hit;
        sensor = lvl;
        tick();
        hit = (lvl != prev_m) && (lvl != fall_m);
        prev_m = lvl;
        chk_bit("input2", lvl, gin2);
        chk_bit("home", hit && homing, home);
        chk_bit("index", hit && armed_m && reg_act, idx);
    endtask : trig

    task automatic lim_write(input int v);
        lim_val = POS_W'(v);
        lim_wr = 1'b1;
        tick();
        lim_wr = 1'b0;
        if (v < 0)
            code_m = 8'h13;
        else
            lim_m = (v > 32767) ? 32767 : v;
        chk_val("limit", 33'(lim_m), 33'(lim_o));
        chk_val("code", 33'(code_m), 33'(code_o));
        chk_bit("error_set", v < 0, eset);
        tick();
    endtask : lim_write

    task automatic proj_start;
        proj = 1'b1;
        tick();
        proj = 1'b0;
        lim_m = 200;
        fail_m = 1'b0;
        att_m = 0;
        wait_m = 1'b0;
        chk_val("limit", 33'(lim_m), 33'(lim_o));
        chk_bit("fail", fail_m, cfail);
    endtask : proj_start

    // One position update against the reference supervisor
    task automatic upd(input int lg);
        int mg;
        bit s, c, x, on;
        mg = (lg < 0) ? -lg : lg;
        on = closed && act != 2'h0 && !wait_m;
        x = on && mg > lim_m;
        s = 1'b0;
        c = 1'b0;
        if (x && act == 2'h1) begin
            s = 1'b1;
            code_m = 8'h85;
        end else if (x && act == 2'h2 && att_m >= int'(atts)) begin
            s = 1'b1;
            code_m = 8'h89;
            fail_m = 1'b1;
        end else if (x && act == 2'h2) begin
            c = 1'b1;
            att_m++;
        end else if (x)
            wait_m = 1'b1;
        else if (on)
            att_m = 0;
        lag = POS_W'(lg);
        pos_upd = 1'b1;
        tick();
        pos_upd = 1'b0;
        chk_val("magnitude", 33'(mg), mag_o);
        chk_bit("stop", s, stop);
        chk_bit("correction", c, corr);
        chk_bit("error_set", s, eset);
        chk_val("code", 33'(code_m), 33'(code_o));
        chk_bit("fail", fail_m, cfail);
        tick();
    endtask : upd

    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : end_sim

    // Watchdog, far beyond the expected run time
    initial begin
        #100000;
        bad_count++;
        end_sim();
    end

    // Main sequence
    initial begin
        seed = 70;
        {sensor, ev_wr, reg_act, homing, pos_upd, closed} = 6'h00;
        {lim_wr, proj, err_clr} = 3'h0;
        {ev_set, lim_val, lag, act, atts, retry} = '0;
        {armed_m, fall_m, prev_m, fail_m, wait_m} = 5'h00;
        code_m = 8'h00;
        lim_m = 200;
        att_m = 0;
        rst_in = 1'b1;
        repeat (2) @(posedge clk_in);
        #1 rst_in = 1'b0;
        chk_val("limit", 33'(lim_m), 33'(lim_o));
        foreach (wr_seq[i])
            ev_write(wr_seq[i]);
        reg_act = 1'b1;
        ev_write(-1);
        ev_write(0);
        homing = 1'b1;
        repeat (24) trig(1'($random(seed)));
        homing = 1'b0;
        ev_write(1);
        repeat (24) trig(1'($random(seed)));
        reg_act = 1'b0;
        lim_write(-5);
        lim_write(40000);
        lim_write(150);
        proj_start();
        err_clr = 1'b1;
        tick();
        err_clr = 1'b0;
        code_m = 8'h00;
        chk_val("code", 33'(code_m), 33'(code_o));
        closed = 1'b1;
        act = 2'h1;
        upd(201);
        upd(200);
        upd(-201);
        repeat (20) upd($random(seed) % 400);
        act = 2'h0;
        upd(500);
        closed = 1'b0;
        act = 2'h1;
        upd(500);
        closed = 1'b1;
        act = 2'h2;
        atts = 8'h02;
        upd(300);
        upd(10);
        repeat (3) upd(300);
        proj_start();
        act = 2'h3;
        // Restart after one retry unit, then with no wait at all
        for (int r = 1; r >= 0; r--) begin
            retry = TIME_W'(r);
            upd(300);
            n = 0;
            while (rstm !== 1'b1 && n < 20) begin
                tick();
                n++;
            end
            wait_m = 1'b0;
            chk_val("restart_delay", 33'(r * TICK), 33'(n));
        end
        end_sim();
    end
endmodule : following_error_and_event_trigger_tb_top
`default_nettype wire

// >>> following_error_magnitude.sv
/*
 Magnitude of commanded minus measured position, and strict compare
 against the limit. Assumes inputs stable within the cycle they are used.
*/
`timescale 1ns/10ps
`default_nettype none
module following_error_magnitude
    import fe_pkg::*;
(
    fe_cmp_if.calc bus
);
    wire signed [MAG_W-1:0] diff;
    wire        [MAG_W-1:0] neg_diff;

    // Sign-extended difference and its absolute value
    assign diff          = {bus.cmd_pos[POS_W-1], bus.cmd_pos}
                         - {bus.enc_pos[POS_W-1], bus.enc_pos}; // see R7
    assign neg_diff      = MAG_W'(-diff);
    assign bus.magnitude = diff[MAG_W-1] ? neg_diff : diff; // see R7
    // Strict greater-than against the stored limit
    assign bus.exceeds   = bus.magnitude
                         > {{(MAG_W-LIMIT_W){1'b0}}, bus.limit}; // see R18
endmodule : following_error_magnitude
`default_nettype wire

// >>> motor_side_model.sv
/*
 Far-side model: step drive, encoder and second event sensor.
 Assumes the bench sets the encoder lag and the sensor level.
*/
`timescale 1ns/10ps
`default_nettype none
module motor_side_model
    import fe_pkg::*;
(
    input  wire logic                    clk_in,
    input  wire logic                    rst_in,
    input  wire logic signed [POS_W-1:0] lag_in,
    input  wire logic                    sensor_in,
    input  wire logic                    stop_in,
    input  wire logic                    go_in,
    output logic signed [POS_W-1:0]      cmd_pos_out,
    output logic signed [POS_W-1:0]      enc_pos_out,
    output logic                         event_out
);
    logic moving_reg;

    // Drive steps once a cycle while moving; stop halts, new move resumes
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            moving_reg  <= 1'b1;
            cmd_pos_out <= 32'h0000_1000;
        end else begin
            if (stop_in)
                moving_reg <= 1'b0;
            else if (go_in)
                moving_reg <= 1'b1;
            if (moving_reg)
                cmd_pos_out <= cmd_pos_out + 32'sh0000_0001;
        end
    end

    // Encoder trails the command by the lag the bench asks for
    assign enc_pos_out = cmd_pos_out - lag_in;
    assign event_out   = sensor_in;
endmodule : motor_side_model
`default_nettype wire
